/* rtl/epm_monitor.v */
// Functional notes
// - coolant low warning after persistent delay
// - coolant check only with measurement present
// - pump check needs assigned output, time
// - pump off on warning, ack restarts
// - pickup check needs nonzero tooth count
// - running with zero speed trips pickup
// - pickup reaction chosen by action field
// - override turns configurable failures to warnings
// - regulator silence beyond timeout trips failure
// - engine silence beyond timeout trips failure
// - types 140-143 watch NMT alive
// - async speed check only in steady running
// - speed over percent of rated trips
// - positive reactive power over threshold alarms
// - engine faults need CAN enabled
// - mask bit suppresses each engine fault
// - overspeed asserts despite other alarms
// - special make masks early oil/coolant faults
// - protections active in all modes; async speed in manual needs breaker closed
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "epm_regs.vh"
module epm_monitor #(
   parameter TICK_CYCLES = (`EPM_CLK_HZ / 1000) * `EPM_TICK_MS
)(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        coolant_present,
   input  wire [15:0] coolant_temp,
   input  wire        pump_request,
   input  wire        engine_running,
   input  wire        engine_started,
   input  wire [15:0] engine_speed,
   input  wire        fuel_active,
   input  wire        start_stop_phase,
   input  wire        volt_freq_ok,
   input  wire        manual_operation,
   input  wire        generator_breaker,
   input  wire [15:0] reactive_power,
   input  wire        avr_msg,
   input  wire        ecu_msg,
   input  wire        nmt_alive,
   input  wire [15:0] can_fault_in,
   output reg         warn_coolant_low,
   output reg         warn_pump_fail,
   output reg         fluid_pump_output_function,
   output reg         pickup_fail,
   output reg  [1:0]  pickup_react,
   output reg         avr_comm_fail,
   output reg  [1:0]  avr_react,
   output reg         ecu_comm_fail,
   output reg         async_speed_trip,
   output reg         reactive_alarm,
   output reg  [15:0] can_faults
);
   localparam NT = 8;
   reg  [31:0] ctrl_r;
   reg  [31:0] cool_r;
   reg  [15:0] pump_r;
   reg  [31:0] pick_r;
   reg  [31:0] tmo_r;
   reg  [31:0] aspd_r;
   reg  [31:0] rate_r;
   reg  [31:0] rpwr_r;
   reg  [31:0] mask_r;
   reg         pump_warn_r;
   reg  [15:0] tick_cnt_r;
   reg         tick_r;
   wire [7:0]  etype = ctrl_r[`EPM_ETYPE_MSB:`EPM_ETYPE_LSB];
   wire        can_en = (etype != 8'h00);
   wire        nmt_type = (etype >= `EPM_NMT_LO) && (etype <= `EPM_NMT_HI);
   wire        ovr = ctrl_r[`EPM_OVR_BIT];
   wire        steady = fuel_active & ~start_stop_phase;
   wire        wr = psel & penable & pwrite & pready;
   wire        ack_pump = wr & (paddr == `EPM_STAT_OFS) & pwdata[`EPM_ST_PUMP];
   wire [15:0] rated = ctrl_r[`EPM_F60_BIT] ? rate_r[31:16] : rate_r[15:0];
   wire [23:0] spd_scaled = engine_speed * `EPM_PCT_SCALE;
   wire [23:0] spd_limit = aspd_r[7:0] * rated;
   wire [15:0] ecu_tmo;
   wire [NT-1:0] cond;
   wire [NT-1:0] trip;
   wire [15:0] dly [0:NT-1];
   wire [31:0] status;
   wire        mask_done;
   wire [15:0] cf_masked;
   reg  [31:0] rd_mux;
   reg         rd_hit;

   // zero timeout stays live on alive-message engines
   assign ecu_tmo = (nmt_type && tmo_r[31:16] == 16'h0000) ? `EPM_NMT_DEF_MS
                                                            : tmo_r[31:16];

   // manual_operation gates async speed to a closed generator_breaker; other checks run in all modes
   assign cond[0] = coolant_present & (coolant_temp < cool_r[15:0]);
   assign cond[1] = ctrl_r[`EPM_PFUN_BIT] & fluid_pump_output_function;
   assign cond[2] = (pick_r[15:0] != 16'h0000) & engine_running
                    & (engine_speed == 16'h0000);
   assign cond[3] = ctrl_r[`EPM_AVR_BIT] & ~avr_msg;
   assign cond[4] = can_en & ~(nmt_type ? nmt_alive : ecu_msg);
   assign cond[5] = steady & volt_freq_ok & (~manual_operation | generator_breaker)
                    & (spd_scaled > spd_limit);
   assign cond[6] = steady & ~reactive_power[15]
                    & (reactive_power > rpwr_r[15:0]);
   assign cond[7] = engine_started;

   assign dly[0] = cool_r[31:16];
   assign dly[1] = pump_r;
   assign dly[2] = pick_r[31:16];
   assign dly[3] = tmo_r[15:0];
   assign dly[4] = ecu_tmo;
   assign dly[5] = aspd_r[31:16];
   assign dly[6] = rpwr_r[31:16];
   assign dly[7] = mask_r[31:16];

   // millisecond time base shared by all timers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tick_cnt_r <= 16'h0000;
         tick_r     <= 1'b0;
      end
      else if (tick_cnt_r == TICK_CYCLES[15:0] - 16'h0001)
      begin
         tick_cnt_r <= 16'h0000;
         tick_r     <= 1'b1;
      end
      else
      begin
         tick_cnt_r <= tick_cnt_r + 16'h0001;
         tick_r     <= 1'b0;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NT; gi = gi + 1)
      begin : g_tmr
         reg [15:0] cnt_r;
         // saturates at the delay; zero delay never trips
         assign trip[gi] = (dly[gi] != 16'h0000) && (cnt_r >= dly[gi]);
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               cnt_r <= 16'h0000;
            else if (!cond[gi])
               cnt_r <= 16'h0000;
            else if (tick_r && cnt_r < dly[gi])
               cnt_r <= cnt_r + 16'h0001;
         end
      end
   endgenerate

   assign mask_done = (mask_r[31:16] == 16'h0000) | trip[7];

   // early oil and coolant reports dropped for the special make
   function [15:0] early_mask;
      input make;
      input done;
      begin
         early_mask = 16'hffff;
         if (make && !done)
         begin
            early_mask[`EPM_CF_OILLO]  = 1'b0;
            early_mask[`EPM_CF_OILMIN] = 1'b0;
            early_mask[`EPM_CF_CLTHI]  = 1'b0;
            early_mask[`EPM_CF_CLTMAX] = 1'b0;
         end
      end
   endfunction

   // overspeed bit is not gated by other alarms
   assign cf_masked = can_fault_in & ~mask_r[15:0] & {16{can_en}}
                      & early_mask(ctrl_r[`EPM_MAKE_BIT], mask_done);

   assign status = {24'h000000, ~mask_done, trip[6:5], ecu_comm_fail,
                    avr_comm_fail, pickup_fail, pump_warn_r, warn_coolant_low};

   always @*
   begin
      rd_hit = 1'b1;
      case (paddr)
         `EPM_CTRL_OFS: rd_mux = ctrl_r;
         `EPM_COOL_OFS: rd_mux = cool_r;
         `EPM_PUMP_OFS: rd_mux = {16'h0000, pump_r};
         `EPM_PICK_OFS: rd_mux = pick_r;
         `EPM_TMO_OFS:  rd_mux = tmo_r;
         `EPM_ASPD_OFS: rd_mux = aspd_r;
         `EPM_RATE_OFS: rd_mux = rate_r;
         `EPM_RPWR_OFS: rd_mux = rpwr_r;
         `EPM_MASK_OFS: rd_mux = mask_r;
         `EPM_STAT_OFS: rd_mux = status;
         default:
         begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   // zero wait states: answer is ready in the first access cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~rd_hit;
         if (psel && !penable && !pwrite)
            prdata <= rd_mux;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= `EPM_CTRL_RST;
         cool_r <= `EPM_WORD_RST;
         pump_r <= 16'h0000;
         pick_r <= `EPM_WORD_RST;
         tmo_r  <= `EPM_WORD_RST;
         aspd_r <= `EPM_WORD_RST;
         rate_r <= `EPM_WORD_RST;
         rpwr_r <= `EPM_WORD_RST;
         mask_r <= `EPM_WORD_RST;
      end
      else if (wr)
      begin
         case (paddr)
            `EPM_CTRL_OFS: ctrl_r <= pwdata;
            `EPM_COOL_OFS: cool_r <= pwdata;
            `EPM_PUMP_OFS: pump_r <= pwdata[15:0];
            `EPM_PICK_OFS: pick_r <= pwdata;
            `EPM_TMO_OFS:  tmo_r  <= pwdata;
            `EPM_ASPD_OFS: aspd_r <= pwdata;
            `EPM_RATE_OFS: rate_r <= pwdata;
            `EPM_RPWR_OFS: rpwr_r <= pwdata;
            `EPM_MASK_OFS: mask_r <= pwdata;
            default:       ctrl_r <= ctrl_r;
         endcase
      end
   end

   // pump warning latches; a new trip wins over the acknowledge
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pump_warn_r <= 1'b0;
      else if (trip[1])
         pump_warn_r <= 1'b1;
      else if (ack_pump)
         pump_warn_r <= 1'b0;
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         warn_coolant_low           <= 1'b0;
         warn_pump_fail             <= 1'b0;
         fluid_pump_output_function <= 1'b0;
         pickup_fail                <= 1'b0;
         pickup_react               <= `EPM_ACT_WARN;
         avr_comm_fail              <= 1'b0;
         avr_react                  <= `EPM_ACT_WARN;
         ecu_comm_fail              <= 1'b0;
         async_speed_trip           <= 1'b0;
         reactive_alarm             <= 1'b0;
         can_faults                 <= 16'h0000;
      end
      else
      begin
         warn_coolant_low           <= trip[0];
         warn_pump_fail             <= pump_warn_r;
         fluid_pump_output_function <= pump_request & ~pump_warn_r & ~trip[1];
         pickup_fail                <= trip[2];
         pickup_react               <= ovr ? `EPM_ACT_WARN
                                           : ctrl_r[`EPM_PACT_LSB+1:`EPM_PACT_LSB];
         avr_comm_fail              <= trip[3];
         avr_react                  <= ovr ? `EPM_ACT_WARN
                                           : ctrl_r[`EPM_AACT_LSB+1:`EPM_AACT_LSB];
         ecu_comm_fail              <= trip[4];
         async_speed_trip           <= trip[5];
         reactive_alarm             <= trip[6];
         can_faults                 <= cf_masked;
      end
   end
endmodule

/* rtl/epm_regs.vh */
`ifndef EPM_REGS_VH
`define EPM_REGS_VH
// register byte offsets
`define EPM_CTRL_OFS  8'h00
`define EPM_COOL_OFS  8'h04
`define EPM_PUMP_OFS  8'h08
`define EPM_PICK_OFS  8'h0c
`define EPM_TMO_OFS   8'h10
`define EPM_ASPD_OFS  8'h14
`define EPM_RATE_OFS  8'h18
`define EPM_RPWR_OFS  8'h1c
`define EPM_MASK_OFS  8'h20
`define EPM_STAT_OFS  8'h24
// control field positions
`define EPM_ETYPE_LSB 0
`define EPM_ETYPE_MSB 7
`define EPM_AVR_BIT   8
`define EPM_OVR_BIT   9
`define EPM_PFUN_BIT  10
`define EPM_MAKE_BIT  11
`define EPM_PACT_LSB  12
`define EPM_AACT_LSB  14
`define EPM_F60_BIT   16
// status field positions
`define EPM_ST_COOL   0
`define EPM_ST_PUMP   1
`define EPM_ST_PICK   2
`define EPM_ST_AVR    3
`define EPM_ST_ECU    4
`define EPM_ST_ASPD   5
`define EPM_ST_RPWR   6
`define EPM_ST_MASKD  7
// can fault mask bits
`define EPM_CF_OILLO  0
`define EPM_CF_OILMIN 1
`define EPM_CF_CLTHI  4
`define EPM_CF_CLTMAX 5
`define EPM_CF_OVSPD  10
// reset values
`define EPM_CTRL_RST  32'h0000_0000
`define EPM_WORD_RST  32'h0000_0000
// reactions
`define EPM_ACT_WARN  2'h0
// timing
`define EPM_CLK_HZ    20000000
`define EPM_TICK_MS   1
`define EPM_NMT_DEF_MS 16'h03e8
`define EPM_NMT_LO    8'h8c
`define EPM_NMT_HI    8'h8f
`define EPM_PCT_SCALE 24'h000064
`endif

/* tb/epm_monitor_assertions.sv */
`timescale 1ns/100ps
module epm_chk (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        pslverr,
   input wire        pump_request,
   input wire        fluid_pump_output_function,
   input wire        warn_pump_fail,
   input wire        coolant_present,
   input wire        warn_coolant_low,
   input wire        fuel_active,
   input wire        async_speed_trip,
   input wire [15:0] can_fault_in,
   input wire [15:0] can_faults
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_ready_in_access: assert property (psel && !penable |=> pready)
      else $error("no ready in access cycle");
   a_ready_only_access: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_pump_off_warn: assert property (warn_pump_fail |-> !fluid_pump_output_function)
      else $error("pump on during warning");
   a_pump_needs_req: assert property (fluid_pump_output_function |-> $past(pump_request))
      else $error("pump on without request");
   a_cool_needs_meas: assert property (!coolant_present [*3] |=> !warn_coolant_low)
      else $error("coolant warning without measurement");
   a_speed_needs_fuel: assert property (!fuel_active [*3] |=> !async_speed_trip)
      else $error("speed trip without fuel control");
   a_fault_from_ecu: assert property ((can_faults & ~$past(can_fault_in)) == 16'h0000)
      else $error("fault not reported by engine");
endmodule
bind epm_monitor epm_chk u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
   .pump_request, .fluid_pump_output_function, .warn_pump_fail, .coolant_present,
   .warn_coolant_low, .fuel_active, .async_speed_trip, .can_fault_in, .can_faults);

/* tb/epm_can_partner.sv */
`timescale 1ns/100ps
module epm_can_partner (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        quiet,
   input  wire        nmt_off,
   input  wire [15:0] faults,
   output reg         avr_msg = 1'b0,
   output reg         ecu_msg = 1'b0,
   output reg         nmt_alive = 1'b0,
   output reg  [15:0] can_fault_in = 16'h0000
);
   reg [1:0] cnt_r = 2'h0;
   // period of four clocks keeps every gap under one timeout tick
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt_r <= 2'h0;
         avr_msg <= 1'b0;
         ecu_msg <= 1'b0;
         nmt_alive <= 1'b0;
         can_fault_in <= 16'h0000;
      end
      else
      begin
         cnt_r <= cnt_r + 2'h1;
         avr_msg <= !quiet && cnt_r == 2'h0;
         ecu_msg <= !quiet && cnt_r == 2'h1;
         nmt_alive <= !quiet && !nmt_off && cnt_r == 2'h2;
         can_fault_in <= faults;
      end
endmodule

/* tb/test_engine_protection_monitor.sv */
`timescale 1ns/100ps
`include "epm_regs.vh"
module test_engine_protection_monitor;
   localparam [7:0]  ST = `EPM_STAT_OFS;
   localparam [31:0] F = 32'hffff_ffff;
   reg         pclk = 1'b0, presetn = 1'b0;
   reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0000_0000;
   reg         coolant_present = 1'b0, pump_request = 1'b0, quiet = 1'b0;
   reg  [15:0] coolant_temp = 16'h0032, faults = 16'h0000;
   reg  [38:0] ri = 39'h00_0000_0000;
   reg  [38:0] rfix = 39'h00_0000_0000;
   reg         hold = 1'b0, nmt_off = 1'b0;
   reg  [31:0] rs = 32'h0000_0017;
   reg  [64:0] q[$];
   reg  [64:0] e;
   integer     miscompares = 0, n_checks = 0, cyc = 0;
   wire [31:0] prdata;
   wire [15:0] can_faults, can_fault_in;
   wire [1:0]  pickup_react, avr_react;
   wire        pready, pslverr, warn_coolant_low, warn_pump_fail, fluid_pump_output_function;
   wire        pickup_fail, avr_comm_fail, ecu_comm_fail, async_speed_trip, reactive_alarm;
   wire        avr_msg, ecu_msg, nmt_alive;

   epm_monitor #(.TICK_CYCLES(4)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .coolant_present, .coolant_temp, .pump_request,
      .engine_running(ri[38]), .engine_started(ri[37]), .engine_speed(ri[15:0]),
      .fuel_active(ri[36]), .start_stop_phase(ri[35]), .volt_freq_ok(ri[34]),
      .manual_operation(ri[33]), .generator_breaker(ri[32]), .reactive_power(ri[31:16]),
      .avr_msg, .ecu_msg, .nmt_alive, .can_fault_in, .warn_coolant_low, .warn_pump_fail,
      .fluid_pump_output_function, .pickup_fail, .pickup_react, .avr_comm_fail, .avr_react,
      .ecu_comm_fail, .async_speed_trip, .reactive_alarm, .can_faults);
   epm_can_partner u_can (.pclk, .presetn, .quiet, .nmt_off, .faults, .avr_msg, .ecu_msg,
      .nmt_alive, .can_fault_in);

   always #25 pclk = ~pclk;

   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction

   task chk(input [32:0] got, input [32:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp)
         begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task stop_test;
      begin
         $display("checks %0d mismatches %0d", n_checks, miscompares);
         if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   task apb(input [7:0] a, input w, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask

   // expected note holds error flag, compare mask and data
   task rd(input [7:0] a, input [32:0] x, input [31:0] m);
      begin
         q.push_back({x[32], m, x[31:0]});
         apb(a, 1'b0, 32'h0000_0000);
      end
   endtask

   task w(input integer n);
      repeat (n) @(posedge pclk);
   endtask

   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
      begin
         e = q.pop_front();
         chk({pslverr, prdata & e[63:32]}, {e[64], e[31:0]});
      end

   // unused checks stay disabled, so noise here must never trip them
   // directed cases pin the engine inputs through hold
   always @(posedge pclk)
   begin
      rs = xs(rs);
      ri <= hold ? rfix : {rs[6:0], rs};
   end

   always @(posedge pclk)
   begin
      cyc = cyc + 1;
      if (cyc == 5000)
      begin
         miscompares = miscompares + 1;
         stop_test;
      end
   end

   initial
   begin
      w(6);
      presetn <= 1'b1;
      w(1);
      rd(`EPM_CTRL_OFS, 33'h0, F);
      rd(ST, 33'h0, F);
      rd(8'h40, 33'h1_0000_0000, F);
      faults <= 16'h0c13;
      w(4);
      chk(can_faults, 33'h0);
      apb(`EPM_CTRL_OFS, 1'b1, 32'h0000_0401);
      apb(`EPM_MASK_OFS, 1'b1, 32'h0000_0011);
      rd(`EPM_CTRL_OFS, 33'h401, F);
      chk(can_faults, 33'h0c02);
      apb(`EPM_COOL_OFS, 1'b1, 32'h0002_0064);
      w(20);
      rd(ST, 33'h0, 32'h0000_0001);
      coolant_present <= 1'b1;
      rd(ST, 33'h0, 32'h0000_0001);
      w(20);
      rd(ST, 33'h1, 32'h0000_0001);
      chk(warn_coolant_low, 33'h1);
      coolant_temp <= 16'h00c8;
      w(4);
      rd(ST, 33'h0, 32'h0000_0001);
      pump_request <= 1'b1;
      w(25);
      chk(fluid_pump_output_function, 33'h1);
      apb(`EPM_PUMP_OFS, 1'b1, 32'h0000_0003);
      w(25);
      rd(ST, 33'h2, 32'h0000_0002);
      chk(fluid_pump_output_function, 33'h0);
      chk(warn_pump_fail, 33'h1);
      apb(ST, 1'b1, 32'h0000_0002);
      w(2);
      chk(fluid_pump_output_function, 33'h1);
      pump_request <= 1'b0;
      rfix <= 39'h40_0000_0000;
      hold <= 1'b1;
      apb(`EPM_CTRL_OFS, 1'b1, 32'h0000_e501);
      apb(`EPM_PICK_OFS, 1'b1, 32'h0002_0001);
      apb(`EPM_TMO_OFS, 1'b1, 32'h0002_0002);
      w(25);
      chk(ecu_comm_fail, 33'h0);
      chk(avr_comm_fail, 33'h0);
      chk(pickup_fail, 33'h1);
      chk(pickup_react, 33'h2);
      quiet <= 1'b1;
      w(25);
      chk(ecu_comm_fail, 33'h1);
      chk(avr_comm_fail, 33'h1);
      chk(avr_react, 33'h3);
      apb(`EPM_CTRL_OFS, 1'b1, 32'h0000_e701);
      w(2);
      chk(avr_react, 33'h0);
      chk(pickup_react, 33'h0);
      quiet <= 1'b0;
      apb(`EPM_PICK_OFS, 1'b1, 32'h0002_0000);
      w(8);
      chk(ecu_comm_fail, 33'h0);
      chk(avr_comm_fail, 33'h0);
      chk(pickup_fail, 33'h0);
      nmt_off <= 1'b1;
      w(25);
      chk(ecu_comm_fail, 33'h0);
      apb(`EPM_CTRL_OFS, 1'b1, 32'h0000_008c);
      w(25);
      chk(ecu_comm_fail, 33'h1);
      nmt_off <= 1'b0;
      w(8);
      chk(ecu_comm_fail, 33'h0);
      rfix <= 39'h00_0000_0000;
      apb(`EPM_MASK_OFS, 1'b1, 32'h0003_0000);
      apb(`EPM_CTRL_OFS, 1'b1, 32'h0000_0801);
      w(2);
      chk(can_faults, 33'h0c00);
      rd(ST, 33'h80, 32'h0000_0080);
      rfix <= 39'h20_0000_0000;
      w(25);
      chk(can_faults, 33'h0c13);
      rd(ST, 33'h0, 32'h0000_0080);
      apb(`EPM_ASPD_OFS, 1'b1, 32'h0002_0032);
      apb(`EPM_RATE_OFS, 1'b1, 32'h07d0_03e8);
      apb(`EPM_RPWR_OFS, 1'b1, 32'h0002_0100);
      rfix <= 39'h34_0200_0258;
      w(25);
      chk(async_speed_trip, 33'h1);
      chk(reactive_alarm, 33'h1);
      rfix <= 39'h36_8200_0258;
      w(8);
      chk(async_speed_trip, 33'h0);
      chk(reactive_alarm, 33'h0);
      rfix <= 39'h37_0200_0258;
      w(25);
      chk(async_speed_trip, 33'h1);
      chk(reactive_alarm, 33'h1);
      rfix <= 39'h24_0200_0258;
      w(8);
      chk(async_speed_trip, 33'h0);
      chk(reactive_alarm, 33'h0);
      apb(`EPM_CTRL_OFS, 1'b1, 32'h0001_0801);
      rfix <= 39'h34_0200_0258;
      w(25);
      chk(async_speed_trip, 33'h0);
      chk(reactive_alarm, 33'h1);
      presetn <= 1'b0;
      w(2);
      chk(reactive_alarm, 33'h0);
      presetn <= 1'b1;
      w(1);
      rd(`EPM_ASPD_OFS, 33'h0, F);
      stop_test;
   end
endmodule
